// ---- rtl/request_checker.sv ----
`timescale 1ns/10ps
module request_checker
  import chk_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic rx_valid,
  input wire logic [7:0] rx_byte,
  input wire logic rx_parity_err,
  input wire logic rx_overrun_err,
  input wire logic rx_framing_err,
  input wire logic frame_end,
  input wire logic [15:0] bit_cycles,
  input wire logic [7:0] own_address,
  input wire logic drive_running,
  input wire logic bus_undervoltage_alarm,
  input wire logic nonvolatile_memory_defect_alarm,
  input wire logic param_busy,
  input wire logic error_reset,
  input wire logic tx_ready,
  output logic tx_valid,
  output logic [7:0] tx_byte,
  output logic result_valid,
  output logic [7:0] result_code,
  output logic enter_eeprom,
  output logic enter_ram,
  output logic [6:0] comm_err_status
);
  state_type state_q;
  logic [7:0] hdr_q [HDR_LEN];
  logic [8:0] idx_q;
  logic [15:0] crc_q;
  logic [7:0] hi_q;
  logic line_err_q, gap_err_q, addr_bad_q, data_bad_q;
  logic [7:0] perm_q;
  logic [2:0] tx_cnt_q;
  logic [15:0] tx_crc_q;
  logic tx_valid_q, result_valid_q, enter_eeprom_q, enter_ram_q;
  logic [7:0] tx_byte_q, result_code_q;
  logic [6:0] status_q;
  gap_if gi();

  // ************************************************************
  // Gap timer
  // ************************************************************
  assign gi.sys_clk = sys_clk;
  assign gi.rst = rst;
  assign gi.ce = ce;
  assign gi.byte_stb = rx_valid;
  assign gi.frame_open = state_q == ST_RECV;
  assign gi.bit_cycles = bit_cycles;
  byte_gap_timer u_gap (.g(gi));

  // ************************************************************
  // Field decode
  // ************************************************************
  logic [15:0] start_w, qty_w, last_w, word_w, wreg_w;
  logic [8:0] wk_w;
  logic f_read, f_loop, f_write, func_ok, bcast, qty_ok, len_ok;
  logic word_stb, addr_bad, qty_bad, silent;
  logic [7:0] code_d, perm_w;
  reg_class_type wcl;

  always_comb
  begin
    start_w = {hdr_q[2], hdr_q[3]};
    qty_w = {hdr_q[4], hdr_q[5]};
    last_w = (qty_w == 16'h0000) ? start_w : start_w + qty_w - QTY_MIN;
    f_read = hdr_q[1] == FC_READ;
    f_loop = hdr_q[1] == FC_LOOP;
    f_write = hdr_q[1] == FC_WRITE;
    bcast = hdr_q[0] == BCAST_ADDR;
    word_w = {hi_q, rx_byte};
    wk_w = (idx_q - LEN_FIXED) >> 1;
    wreg_w = start_w + {7'h00, wk_w};
    word_stb = rx_valid && f_write && idx_q > IDX_DATA && !idx_q[0] &&
      {7'h00, wk_w} < qty_w;
    wcl = reg_class(wreg_w);
    perm_w = EX_NONE;
    case (wcl)
      CL_MON: perm_w = EX_MODE;
      CL_PARAM:
        if (drive_running)
          perm_w = EX_MODE;
        else if (nonvolatile_memory_defect_alarm && !on_whitelist(wreg_w))
          perm_w = EX_MODE;
        else if (bus_undervoltage_alarm)
          perm_w = EX_UNDERVOLT;
        else if (param_busy)
          perm_w = EX_BUSY;
      CL_ENTER:
        if (drive_running)
          perm_w = EX_MODE;
        else if (bus_undervoltage_alarm)
          perm_w = EX_UNDERVOLT;
      default: perm_w = EX_NONE;
    endcase
  end

  always_comb
  begin
    func_ok = f_read || f_loop || f_write;
    if (f_read || f_loop)
      len_ok = idx_q == LEN_FIXED;
    else if (f_write)
      len_ok = idx_q >= LEN_WRITE_BASE &&
        idx_q == LEN_WRITE_BASE + {1'b0, hdr_q[6]};
    else
      len_ok = idx_q >= LEN_MIN;
    silent = line_err_q || gap_err_q || crc_q != CRC_GOOD || !len_ok ||
      !(bcast || hdr_q[0] == own_address);
    if (f_read)
      addr_bad = reg_class(start_w) == CL_NONE ||
        reg_class(start_w) == CL_ENTER ||
        reg_class(start_w) != reg_class(last_w);
    else if (f_write)
      addr_bad = addr_bad_q || reg_class(start_w) == CL_NONE ||
        (bcast && start_w != BCAST_FIRST && start_w != BCAST_LAST);
    else
      addr_bad = 1'b0;
    qty_ok = qty_w >= QTY_MIN && qty_w <= QTY_MAX;
    qty_bad = (f_read || f_write) && !qty_ok ||
      f_write && {8'h00, hdr_q[6]} != {qty_w[14:0], 1'b0};
    if (!func_ok)
      code_d = EX_FUNC;
    else if (addr_bad)
      code_d = EX_ADDR;
    else if (qty_bad)
      code_d = EX_QTY;
    else if (f_write && data_bad_q)
      code_d = EX_DATA;
    else if (f_write)
      code_d = perm_q;
    else
      code_d = EX_NONE;
  end

  // ************************************************************
  // Message sequencing
  // ************************************************************
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      state_q <= ST_IDLE;
    else if (ce)
      case (state_q)
        ST_IDLE: if (rx_valid) state_q <= ST_RECV;
        ST_RECV: if (frame_end) state_q <= ST_CHECK;
        ST_CHECK:
          if (!silent && code_d != EX_NONE && !bcast)
            state_q <= ST_REPLY;
          else
            state_q <= ST_IDLE;
        ST_REPLY:
          if (tx_valid_q && tx_ready && tx_cnt_q == REPLY_LAST)
            state_q <= ST_IDLE;
        default: state_q <= ST_IDLE;
      endcase
  end

  // ************************************************************
  // Receive capture
  // ************************************************************
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < HDR_LEN; i++)
        hdr_q[i] <= 8'h00;
      idx_q <= 9'h000;
      crc_q <= CRC_INIT;
      hi_q <= 8'h00;
      line_err_q <= 1'b0;
      gap_err_q <= 1'b0;
      addr_bad_q <= 1'b0;
      data_bad_q <= 1'b0;
      perm_q <= EX_NONE;
    end
    else if (ce)
    begin
      // Clear at the check so a byte on the first idle edge starts clean
      if (state_q == ST_CHECK || (state_q == ST_IDLE && !rx_valid))
      begin
        idx_q <= 9'h000;
        crc_q <= CRC_INIT;
        line_err_q <= 1'b0;
        gap_err_q <= 1'b0;
        addr_bad_q <= 1'b0;
        data_bad_q <= 1'b0;
        perm_q <= EX_NONE;
      end
      else if (rx_valid && state_q != ST_CHECK && state_q != ST_REPLY)
      begin
        // Checksum runs over the trailer too; a clean frame ends at zero
        crc_q <= crc_step(crc_q, rx_byte);
        if (idx_q < IDX_DATA)
          hdr_q[idx_q[2:0]] <= rx_byte;
        if (idx_q != IDX_MAX)
          idx_q <= idx_q + 9'h001;
        hi_q <= rx_byte;
        if (rx_parity_err || rx_overrun_err || rx_framing_err)
          line_err_q <= 1'b1;
        if (word_stb)
        begin
          if (wcl == CL_NONE)
            addr_bad_q <= 1'b1;
          if ((wcl == CL_PARAM && word_w > PARAM_MAX) ||
            (wcl == CL_ENTER && word_w != ENTER_VALUE))
            data_bad_q <= 1'b1;
          if (perm_q == EX_NONE)
            perm_q <= perm_w;
        end
      end
      if (state_q == ST_RECV && gi.gap_late)
        gap_err_q <= 1'b1;
    end
  end

  // ************************************************************
  // Outcome and commit strobes
  // ************************************************************
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      result_valid_q <= 1'b0;
      result_code_q <= EX_NONE;
      enter_eeprom_q <= 1'b0;
      enter_ram_q <= 1'b0;
    end
    else if (ce)
    begin
      result_valid_q <= state_q == ST_CHECK && !silent;
      enter_eeprom_q <= 1'b0;
      enter_ram_q <= 1'b0;
      if (state_q == ST_CHECK && !silent)
      begin
        result_code_q <= code_d;
        if (code_d == EX_NONE && f_write)
        begin
          enter_eeprom_q <= start_w == ENTER_EEPROM;
          enter_ram_q <= start_w == ENTER_RAM;
        end
      end
    end
  end

  // ************************************************************
  // Exception reply
  // ************************************************************
  logic [15:0] tx_crc_n;
  assign tx_crc_n = crc_step(tx_crc_q, tx_byte_q);

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      tx_valid_q <= 1'b0;
      tx_byte_q <= 8'h00;
      tx_cnt_q <= 3'h0;
      tx_crc_q <= CRC_INIT;
    end
    else if (ce)
    begin
      if (state_q == ST_CHECK && !silent && code_d != EX_NONE && !bcast)
      begin
        tx_valid_q <= 1'b1;
        tx_byte_q <= hdr_q[0];
        tx_cnt_q <= 3'h0;
        tx_crc_q <= CRC_INIT;
      end
      else if (tx_valid_q && tx_ready)
      begin
        tx_cnt_q <= tx_cnt_q + 3'h1;
        if (tx_cnt_q < REPLY_CRC)
          tx_crc_q <= tx_crc_n;
        case (tx_cnt_q)
          3'h0: tx_byte_q <= hdr_q[1] | EXC_FLAG;
          3'h1: tx_byte_q <= result_code_q;
          3'h2: tx_byte_q <= tx_crc_n[7:0];
          3'h3: tx_byte_q <= tx_crc_q[15:8];
          default: tx_valid_q <= 1'b0;
        endcase
      end
    end
  end

  // ************************************************************
  // Error detail word
  // ************************************************************
  logic [6:0] status_set;

  always_comb
  begin
    status_set = 7'h00;
    if (rx_valid && state_q != ST_CHECK && state_q != ST_REPLY)
    begin
      status_set[ST_PAR] = rx_parity_err;
      status_set[ST_OVR] = rx_overrun_err;
      status_set[ST_FRM] = rx_framing_err;
    end
    if (state_q == ST_CHECK)
    begin
      status_set[ST_CRC] = crc_q != CRC_GOOD;
      status_set[ST_LEN] = !len_ok;
      status_set[ST_TMO] = gap_err_q;
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      status_q <= 7'h00;
    else if (ce)
      status_q <= (error_reset ? 7'h00 : status_q) | status_set;
  end

  assign tx_valid = tx_valid_q;
  assign tx_byte = tx_byte_q;
  assign result_valid = result_valid_q;
  assign result_code = result_code_q;
  assign enter_eeprom = enter_eeprom_q;
  assign enter_ram = enter_ram_q;
  assign comm_err_status = status_q;

  // ************************************************************
  // Checks
  // ************************************************************
  func_code_a: assert property (@(posedge sys_clk) disable iff (rst)
    ce && state_q == ST_CHECK && !silent && !func_ok |=>
      result_valid && result_code == EX_FUNC)
    else $error("bad function not answered 01");
  bcast_start_a: assert property (@(posedge sys_clk) disable iff (rst)
    ce && state_q == ST_CHECK && !silent && f_write && bcast &&
      start_w != BCAST_FIRST && start_w != BCAST_LAST |=>
      result_code == EX_ADDR && !tx_valid)
    else $error("broadcast start not refused");
  qty_range_a: assert property (@(posedge sys_clk) disable iff (rst)
    ce && state_q == ST_CHECK && !silent && f_read && !addr_bad &&
      qty_w > QTY_MAX |=> result_code == EX_QTY)
    else $error("count over range not 03");
  enter_read_a: assert property (@(posedge sys_clk) disable iff (rst)
    ce && state_q == ST_CHECK && !silent && f_read &&
      reg_class(start_w) == CL_ENTER |=> result_code == EX_ADDR)
    else $error("commit register read not 02");
  silent_drop_a: assert property (@(posedge sys_clk) disable iff (rst)
    ce && state_q == ST_CHECK && line_err_q |=>
      (!result_valid && !tx_valid) [*2])
    else $error("line error frame answered");
  err_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
    ce && !error_reset && status_q[ST_CRC] |=> status_q[ST_CRC])
    else $error("error detail lost before reset");
  reply_head_a: assert property (@(posedge sys_clk) disable iff (rst)
    ce && tx_valid && tx_ready && tx_cnt_q == 3'h0 |=>
      tx_byte == (hdr_q[1] | EXC_FLAG) && tx_valid)
    else $error("reply function byte wrong");
  commit_pulse_a: assert property (@(posedge sys_clk) disable iff (rst)
    enter_eeprom |-> $past(f_write) && $past(start_w) == ENTER_EEPROM)
    else $error("commit strobe without commit write");
endmodule // request_checker

// ---- rtl/chk_pkg.sv ----
package chk_pkg;
  // ************************************************************
  // Protocol codes
  // ************************************************************
  localparam logic [7:0] FC_READ = 8'h03;
  localparam logic [7:0] FC_LOOP = 8'h08;
  localparam logic [7:0] FC_WRITE = 8'h10;
  localparam logic [7:0] EXC_FLAG = 8'h80;
  localparam logic [7:0] EX_NONE = 8'h00;
  localparam logic [7:0] EX_FUNC = 8'h01;
  localparam logic [7:0] EX_ADDR = 8'h02;
  localparam logic [7:0] EX_QTY = 8'h03;
  localparam logic [7:0] EX_DATA = 8'h21;
  localparam logic [7:0] EX_MODE = 8'h22;
  localparam logic [7:0] EX_UNDERVOLT = 8'h23;
  localparam logic [7:0] EX_BUSY = 8'h24;
  localparam logic [7:0] BCAST_ADDR = 8'h00;
  localparam logic [15:0] QTY_MIN = 16'h0001;
  localparam logic [15:0] QTY_MAX = 16'h0010;
  // ************************************************************
  // Register map
  // ************************************************************
  localparam logic [15:0] BCAST_FIRST = 16'h0001;
  localparam logic [15:0] BCAST_LAST = 16'h0002;
  localparam logic [15:0] CMD_LO = 16'h0001;
  localparam logic [15:0] CMD_HI = 16'h000f;
  localparam logic [15:0] MON_LO = 16'h0020;
  localparam logic [15:0] MON_HI = 16'h003f;
  localparam logic [15:0] PARAM_LO = 16'h0100;
  localparam logic [15:0] PARAM_HI = 16'h05ff;
  localparam logic [15:0] PARAM_MAX = 16'h7fff;
  localparam logic [15:0] ENTER_EEPROM = 16'h0900;
  localparam logic [15:0] ENTER_RAM = 16'h0910;
  localparam logic [15:0] ENTER_VALUE = 16'h0000;
  localparam logic [15:0] SETUP_PARAM_FIRST = 16'h0100;
  localparam logic [15:0] SETUP_PARAM_LAST = 16'h0105;
  localparam logic [15:0] VOLTAGE_PATTERN_PARAM = 16'h0302;
  // ************************************************************
  // Frame layout and timing
  // ************************************************************
  localparam int HDR_LEN = 7;
  localparam logic [8:0] IDX_DATA = 9'h007;
  localparam logic [8:0] IDX_MAX = 9'h1ff;
  localparam logic [8:0] LEN_FIXED = 9'h008;
  localparam logic [8:0] LEN_WRITE_BASE = 9'h009;
  localparam logic [8:0] LEN_MIN = 9'h004;
  localparam logic [15:0] CRC_INIT = 16'hffff;
  localparam logic [15:0] CRC_POLY = 16'ha001;
  localparam logic [15:0] CRC_GOOD = 16'h0000;
  localparam logic [2:0] REPLY_LAST = 3'h4;
  localparam logic [2:0] REPLY_CRC = 3'h3;
  localparam logic [4:0] GAP_BITS = 5'h18;
  localparam int ST_CRC = 0;
  localparam int ST_LEN = 1;
  localparam int ST_PAR = 3;
  localparam int ST_OVR = 4;
  localparam int ST_FRM = 5;
  localparam int ST_TMO = 6;

  typedef enum logic [1:0]
  {
    ST_IDLE = 2'b00,
    ST_RECV = 2'b01,
    ST_CHECK = 2'b11,
    ST_REPLY = 2'b10
  } state_type;

  typedef enum logic [2:0]
  {
    CL_NONE,
    CL_CMD,
    CL_MON,
    CL_PARAM,
    CL_ENTER
  } reg_class_type;

  // ************************************************************
  // Shared functions
  // ************************************************************
  function automatic logic [15:0] crc_step(input logic [15:0] c,
                                           input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++)
      r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    return r;
  endfunction

  function automatic reg_class_type reg_class(input logic [15:0] a);
    if (a >= CMD_LO && a <= CMD_HI)
      return CL_CMD;
    if (a >= MON_LO && a <= MON_HI)
      return CL_MON;
    if (a >= PARAM_LO && a <= PARAM_HI)
      return CL_PARAM;
    if (a == ENTER_EEPROM || a == ENTER_RAM)
      return CL_ENTER;
    return CL_NONE;
  endfunction

  function automatic logic on_whitelist(input logic [15:0] a);
    return (a >= SETUP_PARAM_FIRST && a <= SETUP_PARAM_LAST) ||
      a == VOLTAGE_PATTERN_PARAM;
  endfunction
endpackage

// ---- rtl/gap_if.sv ----
`timescale 1ns/10ps
interface gap_if;
  logic sys_clk;
  logic rst;
  logic ce;
  logic byte_stb;
  logic frame_open;
  logic [15:0] bit_cycles;
  logic gap_late;
  modport timer (input sys_clk, rst, ce, byte_stb, frame_open, bit_cycles,
                 output gap_late);
  modport user (output sys_clk, rst, ce, byte_stb, frame_open, bit_cycles,
                input gap_late);
endinterface

// ---- rtl/byte_gap_timer.sv ----
`timescale 1ns/10ps
module byte_gap_timer
  import chk_pkg::*;
(
  gap_if.timer g
);
  logic [15:0] cyc_q;
  logic [4:0] bits_q;

  // ************************************************************
  // Idle gap in bit times
  // ************************************************************
  // count bit times
  always_ff @(posedge g.sys_clk or posedge g.rst)
  begin
    if (g.rst)
    begin
      cyc_q <= 16'h0000;
      bits_q <= 5'h00;
    end
    else if (g.ce)
    begin
      if (g.byte_stb || !g.frame_open)
      begin
        cyc_q <= 16'h0000;
        bits_q <= 5'h00;
      end
      else if (cyc_q + 16'h0001 >= g.bit_cycles)
      begin
        cyc_q <= 16'h0000;
        // Saturate just past the limit so the flag stays up
        if (bits_q <= GAP_BITS)
          bits_q <= bits_q + 5'h01;
      end
      else
        cyc_q <= cyc_q + 16'h0001;
    end
  end

  assign g.gap_late = bits_q > GAP_BITS;

  gap_late_a: assert property (@(posedge g.sys_clk) disable iff (g.rst)
    g.ce && g.byte_stb |=> !g.gap_late)
    else $error("gap flag right after a byte");
endmodule // byte_gap_timer

// ---- sim/bus_master_model.sv ----
`timescale 1ns/10ps
// ************************************************************
// Serial master stand-in
// ************************************************************
module bus_master_model
(
  input wire logic sys_clk,
  input wire logic tx_valid,
  input wire logic [7:0] tx_byte,
  output logic rx_valid,
  output logic [7:0] rx_byte,
  output logic rx_parity_err,
  output logic rx_overrun_err,
  output logic rx_framing_err,
  output logic frame_end,
  output logic tx_ready
);
  logic [7:0] got[$];

  initial
  begin
    {rx_valid, rx_parity_err, rx_overrun_err, rx_framing_err} = 4'h0;
    frame_end = 1'b0;
    rx_byte = 8'h00;
    tx_ready = 1'b0;
  end

  // Half-rate accept keeps every reply stalling
  always @(posedge sys_clk)
  begin
    if (tx_valid && tx_ready)
      got.push_back(tx_byte);
    tx_ready <= #1 ~tx_ready;
  end

  task automatic send(input logic [7:0] b[$], input int bad, input int kind,
                      input int gap);
    foreach (b[i])
    begin
      @(posedge sys_clk);
      #1;
      rx_valid = 1'b1;
      rx_byte = b[i];
      rx_parity_err = (i == bad && kind == 0);
      rx_overrun_err = (i == bad && kind == 1);
      rx_framing_err = (i == bad && kind == 2);
      @(posedge sys_clk);
      #1;
      {rx_valid, rx_parity_err, rx_overrun_err, rx_framing_err} = 4'h0;
      // Released line shows the inverse, never the old byte
      rx_byte = ~b[i];
      if (i == 1)
        repeat (gap) @(posedge sys_clk);
    end
    @(posedge sys_clk);
    #1;
    frame_end = 1'b1;
    @(posedge sys_clk);
    #1;
    frame_end = 1'b0;
  endtask
endmodule // bus_master_model

// ---- sim/tb_request_checker.sv ----
`timescale 1ns/10ps
module tb_request_checker;
  import chk_pkg::*;
  logic sys_clk, rst, rx_valid, pe, oe, fe, frame_end, tx_ready, tx_valid;
  logic running, undervolt, mem_alarm, busy, error_reset, result_valid;
  logic enter_eeprom, enter_ram;
  logic [7:0] rx_byte, tx_byte, result_code;
  logic [6:0] comm_err_status;
  logic [7:0] q[$];
  int n_fail, n_checks, n_res, n_ee, n_ram;

  request_checker dut (.sys_clk(sys_clk), .rst(rst), .ce(1'b1),
    .rx_valid(rx_valid), .rx_byte(rx_byte), .rx_parity_err(pe),
    .rx_overrun_err(oe), .rx_framing_err(fe), .frame_end(frame_end),
    .bit_cycles(16'h0004), .own_address(8'h05), .drive_running(running),
    .bus_undervoltage_alarm(undervolt),
    .nonvolatile_memory_defect_alarm(mem_alarm),
    .param_busy(busy), .error_reset(error_reset), .tx_ready(tx_ready),
    .tx_valid(tx_valid), .tx_byte(tx_byte), .result_valid(result_valid),
    .result_code(result_code), .enter_eeprom(enter_eeprom),
    .enter_ram(enter_ram), .comm_err_status(comm_err_status));

  bus_master_model m (.sys_clk(sys_clk), .tx_valid(tx_valid),
    .tx_byte(tx_byte), .rx_valid(rx_valid), .rx_byte(rx_byte),
    .rx_parity_err(pe), .rx_overrun_err(oe), .rx_framing_err(fe),
    .frame_end(frame_end), .tx_ready(tx_ready));

  always #10 sys_clk = ~sys_clk;

  always @(posedge sys_clk)
  begin
    n_res += int'(result_valid === 1'b1);
    n_ee += int'(enter_eeprom === 1'b1);
    n_ram += int'(enter_ram === 1'b1);
  end

  function automatic logic [15:0] crc16(input logic [7:0] b[$]);
    logic [15:0] c;
    c = 16'hffff;
    foreach (b[i])
    begin
      c ^= {8'h00, b[i]};
      repeat (8) c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
    end
    return c;
  endfunction

  task automatic check(input string what, input logic [15:0] seen, exp);
    n_checks++;
    if (seen !== exp)
    begin
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
      n_fail++;
    end
  endtask

  task automatic hdr(input logic [7:0] a, f, input logic [15:0] s, n);
    q = '{a, f, s[15:8], s[7:0], n[15:8], n[7:0]};
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] s, v,
                    input logic [7:0] bc, input logic [15:0] n);
    hdr(a, FC_WRITE, s, n);
    q.push_back(bc);
    q.push_back(v[15:8]);
    q.push_back(v[7:0]);
  endtask

  // Code ff means the message must vanish without result or reply
  task automatic go(input logic [7:0] code, input int bad = -1,
                    input int kind = 0, input int gap = 0);
    logic [15:0] c;
    logic [7:0] r[$];
    logic [15:0] n_exp;
    int r0, k;
    c = crc16(q);
    q.push_back(c[7:0]);
    q.push_back(c[15:8]);
    if (kind == 3)
      q[q.size()-1] ^= 8'h01;
    r0 = n_res;
    m.got.delete();
    m.send(q, bad, kind, gap);
    for (k = 0; k < 40 && n_res == r0; k++)
      @(posedge sys_clk) #1;
    n_exp = (code == 8'hff) ? 16'h0000 : 16'h0001;
    check("result count", 16'(n_res - r0), n_exp);
    if (code != 8'hff)
      check("result code", 16'(result_code), 16'(code));
    for (k = 0; k < 60 && m.got.size() < 5; k++)
      @(posedge sys_clk) #1;
    if (code == 8'hff || code == EX_NONE || q[0] == BCAST_ADDR)
      check("reply length", 16'(m.got.size()), 16'h0000);
    else
    begin
      r = '{q[0], q[1] | EXC_FLAG, code};
      c = crc16(r);
      r.push_back(c[7:0]);
      r.push_back(c[15:8]);
      check("reply length", 16'(m.got.size()), 16'h0005);
      foreach (r[i])
        check("reply byte", m.got[i], r[i]);
    end
  endtask

  task automatic summarize;
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Whole run needs well under a third of this span
  initial
  begin
    #1600000;
    n_fail++;
    summarize();
  end

  initial
  begin
    {sys_clk, running, undervolt, mem_alarm, busy, error_reset} = 6'h00;
    {n_fail, n_checks, n_res, n_ee, n_ram} = '0;
    rst = 1'b1;
    repeat (3) @(posedge sys_clk);
    #1;
    rst = 1'b0;
    hdr(8'h05, 8'h04, MON_LO, 16'h0001);
    go(EX_FUNC);
    hdr(8'h05, FC_LOOP, MON_LO, 16'h0001);
    go(EX_NONE);
    hdr(8'h05, FC_READ, 16'h0050, 16'h0001);
    go(EX_ADDR);
    hdr(8'h05, FC_READ, ENTER_EEPROM, 16'h0001);
    go(EX_ADDR);
    hdr(8'h05, FC_READ, MON_LO, 16'h0000);
    go(EX_QTY);
    hdr(8'h05, FC_READ, MON_LO, 16'h0011);
    go(EX_QTY);
    hdr(8'h05, FC_READ, MON_LO, 16'h0010);
    go(EX_NONE);
    hdr(8'h05, FC_READ, 16'h0050, 16'h0000);
    go(EX_ADDR);
    wr(8'h05, PARAM_LO, 16'h0001, 8'h02, 16'h0002);
    go(EX_QTY);
    wr(8'h05, PARAM_LO, 16'h8000, 8'h02, 16'h0001);
    go(EX_DATA);
    wr(8'h05, ENTER_EEPROM, 16'h0001, 8'h02, 16'h0001);
    go(EX_DATA);
    wr(8'h05, MON_LO, 16'h0001, 8'h02, 16'h0001);
    go(EX_MODE);
    running = 1'b1;
    wr(8'h05, PARAM_LO, 16'h0001, 8'h02, 16'h0001);
    go(EX_MODE);
    wr(8'h05, ENTER_EEPROM, 16'h0000, 8'h02, 16'h0001);
    go(EX_MODE);
    wr(8'h05, CMD_LO, 16'h0001, 8'h02, 16'h0001);
    go(EX_NONE);
    {running, mem_alarm} = 2'b01;
    wr(8'h05, 16'h0200, 16'h0001, 8'h02, 16'h0001);
    go(EX_MODE);
    wr(8'h05, 16'h0106, 16'h0001, 8'h02, 16'h0001);
    go(EX_MODE);
    wr(8'h05, 16'h0105, 16'h0001, 8'h02, 16'h0001);
    go(EX_NONE);
    wr(8'h05, 16'h0302, 16'h0001, 8'h02, 16'h0001);
    go(EX_NONE);
    {mem_alarm, undervolt} = 2'b01;
    wr(8'h05, PARAM_LO, 16'h0001, 8'h02, 16'h0001);
    go(EX_UNDERVOLT);
    wr(8'h05, ENTER_RAM, 16'h0000, 8'h02, 16'h0001);
    go(EX_UNDERVOLT);
    {undervolt, busy} = 2'b01;
    wr(8'h05, PARAM_LO, 16'h0001, 8'h02, 16'h0001);
    go(EX_BUSY);
    busy = 1'b0;
    wr(8'h05, ENTER_EEPROM, 16'h0000, 8'h02, 16'h0001);
    go(EX_NONE);
    wr(8'h05, ENTER_RAM, 16'h0000, 8'h02, 16'h0001);
    go(EX_NONE);
    check("commit counts", 16'({n_ee[7:0], n_ram[7:0]}), 16'h0101);
    wr(BCAST_ADDR, 16'h0003, 16'h0001, 8'h02, 16'h0001);
    go(EX_ADDR);
    wr(BCAST_ADDR, BCAST_LAST, 16'h0001, 8'h02, 16'h0001);
    go(EX_NONE);
    for (int kd = 0; kd < 4; kd++)
    begin
      hdr(8'h05, FC_READ, MON_LO, 16'h0001);
      go(8'hff, 2, kd);
    end
    hdr(8'h05, FC_READ, MON_LO, 16'h0001);
    q.push_back(8'h00);
    go(8'hff);
    hdr(8'h06, 8'h04, MON_LO, 16'h0001);
    go(8'hff);
    hdr(8'h05, FC_READ, MON_LO, 16'h0001);
    go(EX_NONE, -1, 0, 80);
    hdr(8'h05, FC_READ, MON_LO, 16'h0001);
    go(8'hff, -1, 0, 110);
    check("error detail", 16'(comm_err_status), 16'h007b);
    @(posedge sys_clk) #1 error_reset = 1'b1;
    @(posedge sys_clk) #1 error_reset = 1'b0;
    @(posedge sys_clk) #1;
    check("error detail", 16'(comm_err_status), 16'h0000);
    summarize();
  end
endmodule // tb_request_checker
